// ===== include/pmbus_pkg.sv
// package: constants for program memory mode and external bus block
package pmbus_pkg;
  // processor modes selected by configuration bits
  typedef enum logic [1:0] {
    PMBUS_MICROPROC = 2'h3, // erased state (unprogrammed)
    PMBUS_EXT_MCU = 2'h2,
    PMBUS_MCU = 2'h1,
    PMBUS_PROT_MCU = 2'h0
  } pmbus_mode_t;
  // address widths and vectors
  localparam int PC_W = 16;
  localparam int WORD_W = 16;
  localparam logic [15:0] RESET_VEC = 16'h0000;
  localparam logic [15:0] INT_VEC0 = 16'h0008;
  localparam logic [15:0] INT_VEC1 = 16'h0010;
  localparam logic [15:0] INT_VEC2 = 16'h0018;
  localparam logic [15:0] INT_VEC3 = 16'h0020;
  // implemented internal program memory size, words
  localparam int INT_WORDS = 256;
  localparam logic [15:0] INT_LIMIT = 16'h0100;
  // start of configuration/test/boot area
  localparam logic [15:0] SPECIAL_BASE = 16'hFE00;
  // unknown data returned above internal memory
  localparam logic [15:0] UNKNOWN_WORD = 16'hFFFF;
  // control port bit positions
  localparam int CTL_ALE = 0;
  localparam int CTL_OE = 1;
  localparam int CTL_WR = 2;
  // external access time budget: 121 ns instruction cycle
  localparam int TCY_NS = 121;
  localparam int CLK_NS = 8;
  localparam int ALE_CYC = 2;
  localparam int OE_CYC = (TCY_NS / CLK_NS) - ALE_CYC; // longest time rounds down
endpackage : pmbus_pkg

// ===== logic/pmbus_mode_dec.sv
// module: decodes processor mode into access permissions
`timescale 1ns/10ps
module pmbus_mode_dec (
  // mode and address
  input wire logic [1:0] mode_i,
  input wire logic [15:0] addr_i,
  // decoded routing
  output logic use_ext_o,
  output logic int_allowed_o,
  output logic special_allowed_o,
  output logic protect_o,
  output logic bus_enabled_o
);
  // combinational decode of mode and fetch address
  always_comb begin
    use_ext_o = 1'b0;
    int_allowed_o = 1'b0;
    special_allowed_o = 1'b0;
    protect_o = 1'b0;
    bus_enabled_o = 1'b0;
    case (pmbus_pkg::pmbus_mode_t'(mode_i))
      pmbus_pkg::PMBUS_MICROPROC: begin // external only
        use_ext_o = 1'b1;
        bus_enabled_o = 1'b1;
      end
      pmbus_pkg::PMBUS_EXT_MCU: begin // switch by address
        use_ext_o = (addr_i >= pmbus_pkg::INT_LIMIT);
        int_allowed_o = 1'b1;
        bus_enabled_o = 1'b1;
      end
      pmbus_pkg::PMBUS_MCU: begin // internal only
        int_allowed_o = 1'b1;
        special_allowed_o = 1'b1;
      end
      pmbus_pkg::PMBUS_PROT_MCU: begin // internal plus protection
        int_allowed_o = 1'b1;
        special_allowed_o = 1'b1;
        protect_o = 1'b1;
      end
      default: begin
        use_ext_o = 1'b1;
      end
    endcase
  end
endmodule : pmbus_mode_dec

// ===== logic/pmbus_fetch.sv
// module: program fetch unit with multiplexed external program bus
// Contract
// - program and data memories use separate buses
// - sixteen-bit counter spans 64K words
// - reset at 0000h, vectors 0008h to 0020h
// - mode comes from configuration bits
// - microcontroller modes fetch internal, unknown above
// - protected mode enables code protection
// - extended mode switches internal/external by address
// - microprocessor mode fetches all externally
// - erased configuration means microprocessor mode
// - special areas only in microcontroller modes
// - data accesses never reach external bus
// - external modes make ports a bus
// - control strobes mirror internal fetches too in extended mode
`timescale 1ns/10ps
module pmbus_fetch (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // configuration bits, 2'b11 when erased
  input wire logic [1:0] CFG_MODE_I,
  // core fetch request side
  input wire logic FETCH_REQ_I,
  input wire logic LOAD_PC_I,
  input wire logic [15:0] LOAD_ADDR_I,
  input wire logic INT_REQ_I,
  input wire logic [1:0] INT_SEL_I,
  output logic FETCH_BUSY_O,
  output logic FETCH_VALID_O,
  output logic [15:0] INSTR_O,
  output logic [15:0] PC_O,
  output logic FETCH_ERR_O,
  output logic CODE_PROTECT_O,
  output logic SPECIAL_OK_O,
  // internal program memory port
  output logic [15:0] INT_ADDR_O,
  input wire logic [15:0] INT_DATA_I,
  // multiplexed address/data ports, low and high
  input wire logic [7:0] LOW_ADDR_DATA_PORT_I,
  output logic [7:0] LOW_ADDR_DATA_PORT_O,
  output logic [7:0] LOW_ADDR_DATA_PORT_OE_O,
  input wire logic [7:0] HIGH_ADDR_DATA_PORT_I,
  output logic [7:0] HIGH_ADDR_DATA_PORT_O,
  output logic [7:0] HIGH_ADDR_DATA_PORT_OE_O,
  // bus control port bits 2:0, active high latch, active low strobes
  output logic [2:0] BUS_CONTROL_PORT_O,
  output logic [2:0] BUS_CONTROL_PORT_OE_O
);
  // fetch sequencer states
  typedef enum logic [1:0] {PMBUS_IDLE, PMBUS_ADDR, PMBUS_DATA, PMBUS_DONE} pmbus_state_t;

  pmbus_state_t state; // sequencer state
  pmbus_state_t next_state;
  logic [15:0] pc; // program counter
  logic [15:0] next_pc;
  logic [15:0] fetch_addr; // address of fetch in flight
  logic [15:0] next_fetch_addr;
  logic [15:0] instr; // captured instruction word
  logic [15:0] next_instr;
  logic [3:0] cnt; // phase cycle counter
  logic [3:0] next_cnt;
  logic valid;
  logic next_valid;
  logic err;
  logic next_err;
  logic [1:0] mode; // latched configuration
  logic [1:0] next_mode;
  logic [7:0] low_s1, low_s2, low_s3; // pin synchronisers
  logic [7:0] high_s1, high_s2, high_s3;
  logic [7:0] low_f, high_f; // pin values once two stages agree
  logic use_ext, int_ok, spec_ok, prot, bus_en;

  // vector select for interrupt entry
  function automatic logic [15:0] vec_of(input logic [1:0] sel);
    case (sel)
      2'h0: vec_of = pmbus_pkg::INT_VEC0;
      2'h1: vec_of = pmbus_pkg::INT_VEC1;
      2'h2: vec_of = pmbus_pkg::INT_VEC2;
      default: vec_of = pmbus_pkg::INT_VEC3;
    endcase
  endfunction : vec_of

  // mode and address decode
  pmbus_mode_dec u_dec (
    .mode_i(mode),
    .addr_i(fetch_addr),
    .use_ext_o(use_ext),
    .int_allowed_o(int_ok),
    .special_allowed_o(spec_ok),
    .protect_o(prot),
    .bus_enabled_o(bus_en)
  );

  // three-stage synchronisers on bus inputs
  always_ff @(posedge REF_CLK_I) begin
    low_s1 <= LOW_ADDR_DATA_PORT_I;
    low_s2 <= low_s1;
    low_s3 <= low_s2;
    high_s1 <= HIGH_ADDR_DATA_PORT_I;
    high_s2 <= high_s1;
    high_s3 <= high_s2;
    // a pin change counts only once the second and third stages agree
    if (low_s2 == low_s3) begin
      low_f <= low_s3;
    end
    if (high_s2 == high_s3) begin
      high_f <= high_s3;
    end
  end

  // next-state logic for sequencer and counter
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_fetch_addr = fetch_addr;
    next_instr = instr;
    next_cnt = cnt;
    next_valid = 1'b0;
    next_err = err;
    next_mode = mode;
    case (state)
      PMBUS_IDLE: begin
        next_mode = CFG_MODE_I; // mode follows configuration bits
        if (INT_REQ_I) begin
          next_pc = vec_of(INT_SEL_I); // vector entry
        end else if (LOAD_PC_I) begin
          next_pc = LOAD_ADDR_I;
        end else if (FETCH_REQ_I) begin
          next_fetch_addr = pc;
          next_pc = pc + 16'h0001; // wraps over 64K words
          next_cnt = 4'h0;
          next_state = PMBUS_ADDR;
        end
      end
      PMBUS_ADDR: begin // address phase with latch strobe
        next_cnt = cnt + 4'h1;
        if (cnt == 4'(pmbus_pkg::ALE_CYC - 1)) begin
          next_cnt = 4'h0;
          next_state = PMBUS_DATA;
        end
      end
      PMBUS_DATA: begin // bus released, read strobe
        next_cnt = cnt + 4'h1;
        if (cnt == 4'(pmbus_pkg::OE_CYC - 1)) begin
          next_state = PMBUS_DONE;
          next_err = 1'b0;
          if (use_ext) begin
            next_instr = {high_f, low_f}; // external word
          end else if (fetch_addr < pmbus_pkg::INT_LIMIT) begin
            next_instr = INT_DATA_I; // external answer discarded
          end else begin
            next_instr = pmbus_pkg::UNKNOWN_WORD; // beyond internal memory
            next_err = 1'b1;
          end
          if (fetch_addr >= pmbus_pkg::SPECIAL_BASE && !spec_ok && !use_ext) begin
            next_instr = pmbus_pkg::UNKNOWN_WORD; // special areas denied
            next_err = 1'b1;
          end
          if (!int_ok && !use_ext) begin
            next_err = 1'b1;
          end
        end
      end
      PMBUS_DONE: begin
        next_valid = 1'b1;
        next_state = PMBUS_IDLE;
      end
      default: next_state = PMBUS_IDLE;
    endcase
  end

  // register update
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state <= PMBUS_IDLE;
      pc <= pmbus_pkg::RESET_VEC;
      fetch_addr <= pmbus_pkg::RESET_VEC;
      instr <= 16'h0000;
      cnt <= 4'h0;
      valid <= 1'b0;
      err <= 1'b0;
      mode <= pmbus_pkg::PMBUS_MICROPROC; // erased default
    end else begin
      state <= next_state;
      pc <= next_pc;
      fetch_addr <= next_fetch_addr;
      instr <= next_instr;
      cnt <= next_cnt;
      valid <= next_valid;
      err <= next_err;
      mode <= next_mode;
    end
  end

  // bus pins: address driven only in address phase, data memory never here
  always_comb begin
    LOW_ADDR_DATA_PORT_O = fetch_addr[7:0];
    HIGH_ADDR_DATA_PORT_O = fetch_addr[15:8];
    LOW_ADDR_DATA_PORT_OE_O = (bus_en && state == PMBUS_ADDR) ? 8'hFF : 8'h00;
    HIGH_ADDR_DATA_PORT_OE_O = (bus_en && state == PMBUS_ADDR) ? 8'hFF : 8'h00;
    BUS_CONTROL_PORT_OE_O = bus_en ? 3'h7 : 3'h0;
    BUS_CONTROL_PORT_O = 3'h6; // idle: latch low, strobes high
    if (bus_en && state == PMBUS_ADDR) begin
      BUS_CONTROL_PORT_O[pmbus_pkg::CTL_ALE] = 1'b1; // toggles even internal
    end
    if (bus_en && state == PMBUS_DATA) begin
      BUS_CONTROL_PORT_O[pmbus_pkg::CTL_OE] = 1'b0;
    end
  end

  // core-side outputs
  assign INT_ADDR_O = fetch_addr;
  assign PC_O = pc;
  assign INSTR_O = instr;
  assign FETCH_VALID_O = valid;
  assign FETCH_ERR_O = err;
  assign FETCH_BUSY_O = (state != PMBUS_IDLE);
  assign CODE_PROTECT_O = prot;
  assign SPECIAL_OK_O = spec_ok;
endmodule : pmbus_fetch

// ===== dv/pmbus_checker.sv
// checker: port timing of the program fetch unit
`timescale 1ns/10ps
module pmbus_checker (
  // clock, reset, requests
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic FETCH_REQ_I,
  input wire logic LOAD_PC_I,
  input wire logic INT_REQ_I,
  input wire logic [1:0] INT_SEL_I,
  // fetch status
  input wire logic FETCH_BUSY_O,
  input wire logic FETCH_VALID_O,
  input wire logic [15:0] PC_O,
  input wire logic CODE_PROTECT_O,
  input wire logic SPECIAL_OK_O,
  // bus pins
  input wire logic [7:0] LOW_ADDR_DATA_PORT_OE_O,
  input wire logic [7:0] HIGH_ADDR_DATA_PORT_OE_O,
  input wire logic [2:0] BUS_CONTROL_PORT_O,
  input wire logic [2:0] BUS_CONTROL_PORT_OE_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // taken fetch answers after the fixed bus walk
  property p_lat;
    FETCH_REQ_I && !FETCH_BUSY_O && !INT_REQ_I && !LOAD_PC_I |-> ##[17:18] FETCH_VALID_O;
  endproperty
  a_lat: assert property (p_lat) else $error("fetch answer late");
  // latch strobe two cycles, then read strobe low
  property p_ale;
    $rose(BUS_CONTROL_PORT_O[0]) |=> BUS_CONTROL_PORT_O[0] ##1 !BUS_CONTROL_PORT_O[1:0];
  endproperty
  a_ale: assert property (p_ale) else $error("strobe order");
  // address phase drives both ports
  property p_adr;
    BUS_CONTROL_PORT_O[0] |-> (LOW_ADDR_DATA_PORT_OE_O & HIGH_ADDR_DATA_PORT_OE_O) == 8'hFF;
  endproperty
  a_adr: assert property (p_adr) else $error("address not driven");
  // bus released while reading
  property p_rel;
    !BUS_CONTROL_PORT_O[1] |-> (LOW_ADDR_DATA_PORT_OE_O | HIGH_ADDR_DATA_PORT_OE_O) == 8'h00;
  endproperty
  a_rel: assert property (p_rel) else $error("bus not released");
  // no write strobe ever
  property p_wr;
    BUS_CONTROL_PORT_O[2];
  endproperty
  a_wr: assert property (p_wr) else $error("write strobe");
  // protected mode keeps bus off
  property p_prot;
    CODE_PROTECT_O |-> SPECIAL_OK_O && BUS_CONTROL_PORT_OE_O == 3'h0;
  endproperty
  a_prot: assert property (p_prot) else $error("protected mode on bus");
  // special areas only in internal modes
  property p_spec;
    SPECIAL_OK_O ^ (BUS_CONTROL_PORT_OE_O == 3'h7);
  endproperty
  a_spec: assert property (p_spec) else $error("special access");
  // vector loaded by select
  property p_int;
    INT_REQ_I && !FETCH_BUSY_O |=> PC_O == {10'h000, {1'b0, $past(INT_SEL_I)} + 3'h1, 3'h0};
  endproperty
  a_int: assert property (p_int) else $error("vector");
  // counter starts at zero
  property p_rst;
    $fell(RST_I) |-> PC_O == 16'h0000 && !FETCH_BUSY_O;
  endproperty
  a_rst: assert property (p_rst) else $error("reset pc");
  c_ext: cover property ($rose(BUS_CONTROL_PORT_O[0]));
  c_int: cover property (INT_REQ_I && !FETCH_BUSY_O);
  c_prot: cover property (CODE_PROTECT_O);
endmodule : pmbus_checker
bind pmbus_fetch pmbus_checker u_chk (.REF_CLK_I, .RST_I, .FETCH_REQ_I, .LOAD_PC_I,
  .INT_REQ_I, .INT_SEL_I, .FETCH_BUSY_O, .FETCH_VALID_O, .PC_O, .CODE_PROTECT_O,
  .SPECIAL_OK_O, .LOW_ADDR_DATA_PORT_OE_O, .HIGH_ADDR_DATA_PORT_OE_O, .BUS_CONTROL_PORT_O,
  .BUS_CONTROL_PORT_OE_O);

// ===== dv/pmbus_ext_mem.sv
// external program memory behind the address latch
`timescale 1ns/10ps
module pmbus_ext_mem (
  // clock and strobes
  input wire logic clk_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  // bus pins and answer delay
  input wire logic [15:0] pin_i,
  input wire logic [3:0] dly_i,
  // word offered to the bus
  output logic [15:0] data_o
);
  logic [15:0] adr = 16'h0000; // latched address
  logic [3:0] cnt = 4'h0; // cycles into read
  initial data_o = 16'h0000;
  // latch address, answer after delay, junk otherwise
  always @(posedge clk_i) begin
    if (ale_i) adr <= pin_i;
    cnt <= rd_n_i ? 4'h0 : cnt + 4'(cnt != 4'hF);
    data_o <= (!rd_n_i && cnt >= dly_i) ? adr ^ 16'h5A3C : ~data_o;
  end
endmodule : pmbus_ext_mem

// ===== dv/tb_top.sv
// testbench: fetch unit against external memory model
`timescale 1ns/10ps
module tb_top;
  logic REF_CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic [1:0] CFG_MODE_I = 2'h3;
  logic FETCH_REQ_I = 1'b0, LOAD_PC_I = 1'b0, INT_REQ_I = 1'b0;
  logic [15:0] LOAD_ADDR_I = 16'h0000;
  logic [1:0] INT_SEL_I = 2'h0;
  logic FETCH_BUSY_O, FETCH_VALID_O, FETCH_ERR_O, CODE_PROTECT_O, SPECIAL_OK_O;
  logic [15:0] INSTR_O, PC_O, INT_ADDR_O, mem_d, pin;
  logic [7:0] lo_o, lo_oe, hi_o, hi_oe;
  logic [2:0] ctl, ctl_oe;
  logic [3:0] dly = 4'h0;
  logic saw_ale = 1'b0;
  int num_errors = 0, num_checks = 0, cyc = 0;
  // memory drives only where the design released
  assign pin = {hi_o & hi_oe | mem_d[15:8] & ~hi_oe, lo_o & lo_oe | mem_d[7:0] & ~lo_oe};
  always #4 REF_CLK_I = ~REF_CLK_I;
  pmbus_fetch u_dut (.REF_CLK_I, .RST_I, .CFG_MODE_I, .FETCH_REQ_I, .LOAD_PC_I, .LOAD_ADDR_I,
    .INT_REQ_I, .INT_SEL_I, .FETCH_BUSY_O, .FETCH_VALID_O, .INSTR_O, .PC_O, .FETCH_ERR_O,
    .CODE_PROTECT_O, .SPECIAL_OK_O, .INT_ADDR_O, .INT_DATA_I(INT_ADDR_O ^ 16'hC3A5),
    .LOW_ADDR_DATA_PORT_I(pin[7:0]), .LOW_ADDR_DATA_PORT_O(lo_o), .LOW_ADDR_DATA_PORT_OE_O(lo_oe),
    .HIGH_ADDR_DATA_PORT_I(pin[15:8]), .HIGH_ADDR_DATA_PORT_O(hi_o),
    .HIGH_ADDR_DATA_PORT_OE_O(hi_oe), .BUS_CONTROL_PORT_O(ctl), .BUS_CONTROL_PORT_OE_O(ctl_oe));
  pmbus_ext_mem u_mem (.clk_i(REF_CLK_I), .ale_i(ctl[0] & ctl_oe[0]),
    .rd_n_i(ctl[1] | ~ctl_oe[1]), .pin_i(pin), .dly_i(dly), .data_o(mem_d));
  // timeout and latch strobe watch
  always @(posedge REF_CLK_I) begin
    cyc++;
    if (ctl[0] === 1'b1) saw_ale <= 1'b1;
    if (cyc == 5000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask : chk
  task automatic print_verdict;
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // load pc, fetch one word, judge word, error, pc and strobes
  task automatic fetch(input logic [15:0] a, w, input logic err, ale);
    int n;
    n = 0;
    LOAD_ADDR_I <= a;
    LOAD_PC_I <= 1'b1;
    @(posedge REF_CLK_I);
    LOAD_PC_I <= 1'b0;
    FETCH_REQ_I <= 1'b1;
    saw_ale <= 1'b0;
    @(posedge REF_CLK_I);
    FETCH_REQ_I <= 1'b0;
    do begin
      @(posedge REF_CLK_I);
      #1;
      n++;
    end while (FETCH_VALID_O !== 1'b1 && n < 40);
    chk(INSTR_O === w && FETCH_ERR_O === err, "fetch word");
    chk(PC_O === a + 16'h0001 && saw_ale === ale, "pc or strobes");
    chk(FETCH_VALID_O === 1'b1, "no answer");
    chk(n == pmbus_pkg::ALE_CYC + pmbus_pkg::OE_CYC + 1, "answer timing");
    @(posedge REF_CLK_I);
  endtask : fetch
  // select mode, judge flags and bus enables
  task automatic set_mode(input logic [1:0] m);
    CFG_MODE_I <= m;
    repeat (2) @(posedge REF_CLK_I);
    #1;
    chk(CODE_PROTECT_O === (m == 2'h0) && SPECIAL_OK_O === (m < 2'h2), "mode flags");
    chk(ctl_oe === {3{m[1]}}, "bus enables");
    @(posedge REF_CLK_I);
  endtask : set_mode
  // all four vectors
  task automatic t_vectors;
    for (int s = 0; s < 4; s++) begin
      INT_SEL_I <= 2'(s);
      INT_REQ_I <= 1'b1;
      @(posedge REF_CLK_I);
      INT_REQ_I <= 1'b0;
      #1;
      chk(PC_O === 16'(8 * s + 8), "vector");
      @(posedge REF_CLK_I);
    end
  endtask : t_vectors
  // main sequence
  initial begin
    repeat (10) @(posedge REF_CLK_I);
    RST_I <= 1'b0;
    #1;
    chk(PC_O === 16'h0000 && FETCH_BUSY_O === 1'b0, "reset state");
    @(posedge REF_CLK_I);
    set_mode(2'h3);
    fetch(16'h0010, 16'h0010 ^ 16'h5A3C, 1'b0, 1'b1);
    dly <= 4'h6;
    fetch(16'hFFFF, 16'hFFFF ^ 16'h5A3C, 1'b0, 1'b1);
    dly <= 4'h0;
    set_mode(2'h2);
    fetch(16'h00FF, 16'h00FF ^ 16'hC3A5, 1'b0, 1'b1);
    fetch(16'h0100, 16'h0100 ^ 16'h5A3C, 1'b0, 1'b1);
    set_mode(2'h1);
    fetch(16'h0020, 16'h0020 ^ 16'hC3A5, 1'b0, 1'b0);
    fetch(16'h0100, 16'hFFFF, 1'b1, 1'b0);
    set_mode(2'h0);
    t_vectors();
    print_verdict();
  end
endmodule : tb_top
